// File: hdl/cdiu_pkg.sv
package cdiu_pkg;

    // ==========================================================
    // Text memory map
    localparam logic [6:0] CDIU_TEXT_FIRST    = 7'h00;
    localparam logic [6:0] CDIU_TEXT_LAST_L0  = 7'h27;
    localparam logic [6:0] CDIU_TEXT_LINE1    = 7'h40;
    localparam logic [6:0] CDIU_TEXT_LAST_L1  = 7'h67;
    localparam logic [6:0] CDIU_TEXT_COLS     = 7'h28;
    localparam logic [5:0] CDIU_VIEW_LAST     = 6'h27;
    localparam int         CDIU_TEXT_DEPTH    = 80;
    localparam logic [7:0] CDIU_SPACE_CODE    = 8'h20;

    // ==========================================================
    // Glyph memory
    localparam int         CDIU_GLYPH_DEPTH   = 64;
    localparam int         CDIU_GLYPH_BITS    = 5;
    localparam logic [3:0] CDIU_USER_CODE_HI  = 4'h0;
    localparam logic [2:0] CDIU_CURSOR_ROW    = 3'h7;
    localparam logic [4:0] CDIU_ALL_PIXELS    = 5'h1f;
    localparam logic [4:0] CDIU_NO_PIXELS     = 5'h00;

    // ==========================================================
    // Instruction field positions
    localparam int CDIU_BIT_ENTRY_UP    = 1;
    localparam int CDIU_BIT_ENTRY_SHIFT = 0;
    localparam int CDIU_BIT_DISP_ON     = 2;
    localparam int CDIU_BIT_CURSOR_ON   = 1;
    localparam int CDIU_BIT_BLINK_ON    = 0;
    localparam int CDIU_BIT_SHIFT_VIEW  = 3;
    localparam int CDIU_BIT_SHIFT_RIGHT = 2;
    localparam logic [7:0] CDIU_INSTR_CLEAR = 8'h01;

    // ==========================================================
    // Timing
    localparam int CDIU_CLK_HZ          = 20000000;
    localparam int CDIU_BLINK_HALF_MS   = 500;
    localparam int CDIU_BLINK_HALF_CYC  = CDIU_CLK_HZ / 1000 * CDIU_BLINK_HALF_MS;

endpackage : cdiu_pkg

// File: hdl/cdiu_glyph_mem.sv
`timescale 1ns/1ns
`default_nettype none

module cdiu_glyph_mem
    import cdiu_pkg::*;
(
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_we,
    input  wire logic [5:0]                 i_waddr,
    input  wire logic [CDIU_GLYPH_BITS-1:0] i_wdata,
    input  wire logic [5:0]                 i_raddr_a,
    output logic      [CDIU_GLYPH_BITS-1:0] o_rdata_a,
    input  wire logic [5:0]                 i_raddr_b,
    output logic      [CDIU_GLYPH_BITS-1:0] o_rdata_b
);

    typedef struct packed {
        logic [CDIU_GLYPH_DEPTH-1:0][CDIU_GLYPH_BITS-1:0] mem;
    } cdiu_glyph_s;

    cdiu_glyph_s st_q;
    cdiu_glyph_s st_d;

    // ==========================================================
    // Storage: only five bits per row exist, upper bits are dropped
    always_comb begin
        st_d = st_q;
        if (i_we) begin
            st_d.mem[i_waddr] = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata_a = st_q.mem[i_raddr_a];
    assign o_rdata_b = st_q.mem[i_raddr_b];

    // ==========================================================
    // Checks
    property p_glyph_keep;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_we |=> st_q.mem[$past(i_waddr)] == $past(i_wdata);
    endproperty
    a_glyph_keep: assert property (p_glyph_keep) else $error("glyph row not stored");

endmodule : cdiu_glyph_mem

`default_nettype wire

// File: hdl/cdiu_core.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Glyph memory holds eight 5x8 user glyphs at addresses 00H to 3FH.
// - A one bit in a glyph row lights its pixel, zero leaves it dark.
// - Unused glyph locations are storage keeping only the low five bits.
// - Codes 00H-07H and 08H-0FH both select user glyphs, bit 3 ignored.
// - Clear fills text with 20H, homes counter, unshifts view, forces step-up.
// - Home sets counter to text 00H and unshifts view, memories kept.
// - Entry mode latches direction and shift enable; zero decrements, shifts right.
// - Direction one increments counter and shifts view left after text writes.
// - View auto-shift only after text writes with shift enabled.
// - Display control bit 2 blanks or shows text, nothing else changes.
// - Blink alternates an all-on cell with the cursor cell near 1Hz.
// - Shift instruction steps counter up on bit 2 one, down on zero.
// - With view select set the view shifts left on zero, right on one.
// - After a shift instruction the counter addresses text memory.
// - Address read returns counter on bits 6..0 and busy flag zero.
// - Text addresses wrap 27H/40H and 67H/00H, glyph addresses 3FH/00H.
// - Data write stores at counter in selected memory, then steps per entry mode.
module cdiu_core
    import cdiu_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = CDIU_BLINK_HALF_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_req,
    input  wire logic       i_register_select,
    input  wire logic       i_read,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_rd_data,
    output logic            o_rd_valid,
    input  wire logic       i_scan_line,
    input  wire logic [4:0] i_scan_col,
    input  wire logic [2:0] i_scan_row,
    output logic      [4:0] o_scan_bits,
    output logic      [7:0] o_scan_code,
    output logic            o_scan_user,
    output logic      [6:0] o_address_counter,
    output logic            o_glyph_select,
    output logic            o_step_up,
    output logic            o_shift_enable,
    output logic            o_display_on,
    output logic            o_cursor_on,
    output logic            o_blink_on,
    output logic            o_blink_phase,
    output logic      [5:0] o_view_offset
);

    typedef struct packed {
        logic [CDIU_TEXT_DEPTH-1:0][7:0] text_mem;
        logic [6:0]                      ac;
        logic                            glyph_sel, step_up, shift_en, disp_on, cursor_on, blink_on;
        logic [5:0]                      view;
        logic [23:0]                     blink_cnt;
        logic                            blink_phase;
        logic [7:0]                      rd_data;
        logic                            rd_valid;
        logic [4:0]                      scan_bits;
        logic [7:0]                      scan_code;
        logic                            scan_user;
    } cdiu_state_s;

    localparam cdiu_state_s ST_RESET = '{
        text_mem: {CDIU_TEXT_DEPTH{CDIU_SPACE_CODE}},
        ac: CDIU_TEXT_FIRST, glyph_sel: 1'b0, step_up: 1'b1, shift_en: 1'b0,
        disp_on: 1'b0, cursor_on: 1'b0, blink_on: 1'b0, view: 6'h00,
        blink_cnt: 24'h00_0000, blink_phase: 1'b0, rd_data: 8'h00, rd_valid: 1'b0,
        scan_bits: 5'h00, scan_code: 8'h00, scan_user: 1'b0
    };

    cdiu_state_s st_q;
    cdiu_state_s st_d;

    // ==========================================================
    // Helpers
    function automatic logic [6:0] step_ac(input logic [6:0] a, input logic up, input logic glyph);
        logic [6:0] r;
        r = a;
        if (glyph) begin
            r = up ? {1'b0, 6'(a[5:0] + 6'h01)} : {1'b0, 6'(a[5:0] - 6'h01)};
        end else if (up) begin
            if (a == CDIU_TEXT_LAST_L0) r = CDIU_TEXT_LINE1;
            else if (a == CDIU_TEXT_LAST_L1) r = CDIU_TEXT_FIRST;
            else r = 7'(a + 7'h01);
        end else begin
            if (a == CDIU_TEXT_LINE1) r = CDIU_TEXT_LAST_L0;
            else if (a == CDIU_TEXT_FIRST) r = CDIU_TEXT_LAST_L1;
            else r = 7'(a - 7'h01);
        end
        return r;
    endfunction : step_ac

    // Left means content moves left, so the view origin advances
    function automatic logic [5:0] shift_view(input logic [5:0] v, input logic left);
        logic [5:0] r;
        r = v;
        if (left) r = (v == CDIU_VIEW_LAST) ? 6'h00 : 6'(v + 6'h01);
        else r = (v == 6'h00) ? CDIU_VIEW_LAST : 6'(v - 6'h01);
        return r;
    endfunction : shift_view

    // Gaps 28H-3FH and 68H-7FH have no storage: writes drop, reads give zero
    function automatic logic [7:0] text_index(input logic [6:0] a);
        return a[6] ? 8'(a[5:0] + CDIU_TEXT_COLS) : {2'b00, a[5:0]};
    endfunction : text_index

    logic       is_instr, is_ac_rd, is_wr, is_rd, host_ok, scan_user, at_cursor;
    logic [7:0] host_idx, scan_idx, scan_code;
    logic [4:0] glyph_host, glyph_scan;
    logic [6:0] scan_sum, scan_addr;

    assign is_instr = i_req && !i_register_select && !i_read;
    assign is_ac_rd = i_req && !i_register_select && i_read;
    assign is_wr    = i_req && i_register_select && !i_read;
    assign is_rd    = i_req && i_register_select && i_read;
    assign host_idx = text_index(st_q.ac);
    assign host_ok  = st_q.ac[5:0] < CDIU_TEXT_COLS[5:0];

    // Scan cell address follows the view offset around each 40-cell line
    assign scan_sum  = 7'({1'b0, st_q.view} + {2'b00, i_scan_col});
    assign scan_addr = {i_scan_line, (scan_sum >= CDIU_TEXT_COLS) ? 6'(scan_sum - CDIU_TEXT_COLS) : scan_sum[5:0]};
    assign scan_idx  = text_index(scan_addr);
    assign scan_code = st_q.text_mem[scan_idx];
    assign scan_user = scan_code[7:4] == CDIU_USER_CODE_HI;
    assign at_cursor = !st_q.glyph_sel && (scan_addr == st_q.ac);

    cdiu_glyph_mem u_glyph (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_we      (is_wr && st_q.glyph_sel),
        .i_waddr   (st_q.ac[5:0]),
        .i_wdata   (i_data[CDIU_GLYPH_BITS-1:0]),
        .i_raddr_a (st_q.ac[5:0]),
        .o_rdata_a (glyph_host),
        .i_raddr_b ({scan_code[2:0], i_scan_row}),
        .o_rdata_b (glyph_scan)
    );

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.rd_valid = 1'b0;
        if (st_q.blink_cnt == 24'(BLINK_HALF_CYCLES - 1)) begin
            st_d.blink_cnt   = 24'h00_0000;
            st_d.blink_phase = !st_q.blink_phase;
        end else begin
            st_d.blink_cnt = 24'(st_q.blink_cnt + 24'h00_0001);
        end

        if (is_instr) begin
            casez (i_data)
                8'b1???_????: begin
                    st_d.ac        = i_data[6:0];
                    st_d.glyph_sel = 1'b0;
                end
                8'b01??_????: begin
                    st_d.ac        = {1'b0, i_data[5:0]};
                    st_d.glyph_sel = 1'b1;
                end
                8'b001?_????: begin
                    // Bus width, lines and brightness have no effect here
                end
                8'b0001_????: begin
                    st_d.ac        = step_ac(st_q.ac, i_data[CDIU_BIT_SHIFT_RIGHT], 1'b0);
                    st_d.glyph_sel = 1'b0;
                    if (i_data[CDIU_BIT_SHIFT_VIEW]) begin
                        st_d.view = shift_view(st_q.view, !i_data[CDIU_BIT_SHIFT_RIGHT]);
                    end
                end
                8'b0000_1???: begin
                    st_d.disp_on   = i_data[CDIU_BIT_DISP_ON];
                    st_d.cursor_on = i_data[CDIU_BIT_CURSOR_ON];
                    st_d.blink_on  = i_data[CDIU_BIT_BLINK_ON];
                end
                8'b0000_01??: begin
                    st_d.step_up  = i_data[CDIU_BIT_ENTRY_UP];
                    st_d.shift_en = i_data[CDIU_BIT_ENTRY_SHIFT];
                end
                8'b0000_001?: begin
                    st_d.ac        = CDIU_TEXT_FIRST;
                    st_d.glyph_sel = 1'b0;
                    st_d.view      = 6'h00;
                end
                8'b0000_0001: begin
                    st_d.text_mem  = {CDIU_TEXT_DEPTH{CDIU_SPACE_CODE}};
                    st_d.ac        = CDIU_TEXT_FIRST;
                    st_d.glyph_sel = 1'b0;
                    st_d.view      = 6'h00;
                    st_d.step_up   = 1'b1;
                end
                default: ;
            endcase
        end else if (is_ac_rd) begin
            st_d.rd_data  = {1'b0, st_q.ac};
            st_d.rd_valid = 1'b1;
        end else if (is_wr || is_rd) begin
            if (is_rd) begin
                st_d.rd_valid = 1'b1;
                st_d.rd_data  = st_q.glyph_sel ? {3'b000, glyph_host} :
                                host_ok ? st_q.text_mem[host_idx] : 8'h00;
            end else if (!st_q.glyph_sel && host_ok) begin
                st_d.text_mem[host_idx] = i_data;
            end
            st_d.ac = step_ac(st_q.ac, st_q.step_up, st_q.glyph_sel);
            if (is_wr && !st_q.glyph_sel && st_q.shift_en) begin
                st_d.view = shift_view(st_q.view, st_q.step_up);
            end
        end

        // Render one pixel row of the scanned cell; font codes above 0FH come from outside
        st_d.scan_code = scan_code;
        st_d.scan_user = scan_user;
        if (!st_q.disp_on) st_d.scan_bits = CDIU_NO_PIXELS;
        else if (at_cursor && st_q.blink_on && st_q.blink_phase) st_d.scan_bits = CDIU_ALL_PIXELS;
        else if (at_cursor && st_q.cursor_on && i_scan_row == CDIU_CURSOR_ROW) st_d.scan_bits = CDIU_ALL_PIXELS;
        else if (scan_user) st_d.scan_bits = glyph_scan;
        else st_d.scan_bits = CDIU_NO_PIXELS;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rd_data         = st_q.rd_data;
    assign o_rd_valid        = st_q.rd_valid;
    assign o_scan_bits       = st_q.scan_bits;
    assign o_scan_code       = st_q.scan_code;
    assign o_scan_user       = st_q.scan_user;
    assign o_address_counter = st_q.ac;
    assign o_glyph_select    = st_q.glyph_sel;
    assign o_step_up         = st_q.step_up;
    assign o_shift_enable    = st_q.shift_en;
    assign o_display_on      = st_q.disp_on;
    assign o_cursor_on       = st_q.cursor_on;
    assign o_blink_on        = st_q.blink_on;
    assign o_blink_phase     = st_q.blink_phase;
    assign o_view_offset     = st_q.view;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_clear;
        is_instr && i_data == CDIU_INSTR_CLEAR;
    endsequence
    sequence s_text_write_up_at_end;
        is_wr && !st_q.glyph_sel && st_q.step_up && st_q.ac == CDIU_TEXT_LAST_L0;
    endsequence

    property p_clear;
        s_clear |=> st_q.ac == CDIU_TEXT_FIRST && st_q.view == 6'h00 && st_q.step_up
                    && !st_q.glyph_sel && st_q.text_mem[CDIU_TEXT_DEPTH-1] == CDIU_SPACE_CODE;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not reset state");
    property p_home;
        is_instr && i_data[7:1] == 7'h01 |=> st_q.ac == CDIU_TEXT_FIRST && st_q.view == 6'h00
                                           && $stable(st_q.step_up);
    endproperty
    a_home: assert property (p_home) else $error("home wrong");
    property p_entry;
        is_instr && i_data[7:2] == 6'h01 |=> st_q.step_up == $past(i_data[1]) && st_q.shift_en == $past(i_data[0]);
    endproperty
    a_entry: assert property (p_entry) else $error("entry mode not latched");
    property p_wrap;
        s_text_write_up_at_end |=> st_q.ac == CDIU_TEXT_LINE1;
    endproperty
    a_wrap: assert property (p_wrap) else $error("text wrap wrong");
    property p_no_shift_read;
        is_rd |=> $stable(st_q.view);
    endproperty
    a_no_shift_read: assert property (p_no_shift_read) else $error("view moved on read");
    property p_ac_read;
        is_ac_rd |=> o_rd_valid && o_rd_data == {1'b0, $past(st_q.ac)};
    endproperty
    a_ac_read: assert property (p_ac_read) else $error("address read wrong");
    property p_shift_text;
        is_instr && i_data[7:4] == 4'h1 |=> !st_q.glyph_sel;
    endproperty
    a_shift_text: assert property (p_shift_text) else $error("shift left glyph mode");
    property p_disp_ctrl;
        is_instr && i_data[7:3] == 5'h01 |=> st_q.disp_on == $past(i_data[2]) && $stable(st_q.ac);
    endproperty
    a_disp_ctrl: assert property (p_disp_ctrl) else $error("display control wrong");

endmodule : cdiu_core

`default_nettype wire

// File: tb/cdiu_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Host side: one access per call, driven on the falling edge
module cdiu_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rd_data,
    output logic            o_req,
    output logic            o_register_select,
    output logic            o_read,
    output logic      [7:0] o_data
);
    logic [7:0] last_rd;
    logic       last_valid;

    initial begin
        o_req             = 1'b0;
        o_register_select = 1'b0;
        o_read            = 1'b0;
        o_data            = 8'h00;
        last_rd           = 8'h00;
        last_valid        = 1'b0;
    end

    // Held one full cycle so the rising edge takes it; the answer is taken half a cycle after that edge
    task automatic access(input logic rs, input logic rd, input logic [7:0] d);
        @(negedge i_clk);
        o_req             = 1'b1;
        o_register_select = rs;
        o_read            = rd;
        o_data            = d;
        @(negedge i_clk);
        o_req      = 1'b0;
        // Released bus shows the inverse so stale data cannot pass for a fresh value
        o_data     = ~d;
        last_valid = i_rd_valid;
        last_rd    = i_rd_data;
    endtask : access
endmodule : cdiu_host_model

`default_nettype wire

// File: tb/test_char_display_instruction_unit.sv
`timescale 1ns/1ns
`default_nettype none

module test_char_display_instruction_unit;
    import cdiu_pkg::*;
    localparam int BLINK = 8;
    logic       i_clk = 1'b0;
    logic       i_rst_n = 1'b0;
    logic       s_line = 1'b0;
    logic [4:0] s_col = 5'h00;
    logic [2:0] s_row = 3'h0;
    logic       req, rs, rd, gsel, up, sh, don, con, bon, ph, rdv, suser;
    logic [7:0] data, rdd, scode;
    logic [6:0] ac;
    logic [5:0] view;
    logic [4:0] sbits;
    int         error_cnt = 0;
    int         compares = 0;
    int         cyc = 0;

    always #25 i_clk = ~i_clk;

    cdiu_host_model host (.i_clk(i_clk), .i_rd_valid(rdv), .i_rd_data(rdd), .o_req(req),
        .o_register_select(rs), .o_read(rd), .o_data(data));

    cdiu_core #(.BLINK_HALF_CYCLES(BLINK)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req),
        .i_register_select(rs), .i_read(rd), .i_data(data), .o_rd_data(rdd), .o_rd_valid(rdv),
        .i_scan_line(s_line), .i_scan_col(s_col), .i_scan_row(s_row), .o_scan_bits(sbits),
        .o_scan_code(scode), .o_scan_user(suser), .o_address_counter(ac), .o_glyph_select(gsel),
        .o_step_up(up), .o_shift_enable(sh), .o_display_on(don), .o_cursor_on(con),
        .o_blink_on(bon), .o_blink_phase(ph), .o_view_offset(view));

    // ==========================================================
    // Shared helpers
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr_i(input logic [7:0] b);
        host.access(1'b0, 1'b0, b);
    endtask : wr_i

    task automatic wr_d(input logic [7:0] b);
        host.access(1'b1, 1'b0, b);
    endtask : wr_d

    task automatic rd_d();
        host.access(1'b1, 1'b1, 8'h00);
    endtask : rd_d

    task automatic scan(input logic l, input logic [4:0] c, input logic [2:0] r);
        @(negedge i_clk);
        s_line = l;
        s_col  = c;
        s_row  = r;
        @(negedge i_clk);
    endtask : scan

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk("counter", {1'b0, ac}, 8'h00);
        chk("step up", {7'h00, up}, 8'h01);
        chk("shift en", {7'h00, sh}, 8'h00);
        chk("display", {5'h00, don, con, bon}, 8'h00);
        rd_d();
        chk("text 00", host.last_rd, 8'h20);
        $display("test reset done");
    endtask : t_reset

    task automatic t_text();
        wr_i(8'ha7); wr_d(8'h41);
        chk("counter", {1'b0, ac}, 8'h40);
        wr_i(8'ha7); rd_d();
        chk("read", host.last_rd, 8'h41);
        wr_i(8'he7); wr_d(8'h44);
        chk("counter", {1'b0, ac}, 8'h00);
        wr_i(8'h04); wr_i(8'hc0); wr_d(8'h42);
        chk("counter", {1'b0, ac}, 8'h27);
        wr_i(8'h80); wr_d(8'h43);
        chk("counter", {1'b0, ac}, 8'h67);
        wr_i(8'h80); rd_d();
        chk("read", host.last_rd, 8'h43);
        wr_i(8'h06);
        $display("test text done");
    endtask : t_text

    task automatic t_glyph();
        // Shift enabled so a glyph write that moved the view would show
        wr_i(8'h07); wr_i(8'h7f); wr_d(8'hff);
        chk("view", {2'h0, view}, 8'h00);
        chk("counter", {1'b0, ac}, 8'h00);
        chk("glyph sel", {7'h00, gsel}, 8'h01);
        wr_i(8'h7f); rd_d();
        chk("glyph read", host.last_rd, 8'h1f);
        chk("view", {2'h0, view}, 8'h00);
        wr_i(8'h40); wr_i(8'h04); wr_d(8'h01);
        chk("counter", {1'b0, ac}, 8'h3f);
        wr_i(8'h06);
        $display("test glyph done");
    endtask : t_glyph

    task automatic t_shift();
        wr_i(8'h02); wr_i(8'h07);
        chk("shift en", {7'h00, sh}, 8'h01);
        wr_d(8'h20);
        chk("view", {2'h0, view}, 8'h01);
        wr_i(8'h05); wr_d(8'h20);
        chk("view", {2'h0, view}, 8'h00);
        rd_d();
        chk("view", {2'h0, view}, 8'h00);
        chk("counter", {1'b0, ac}, 8'h67);
        wr_i(8'h18);
        chk("counter", {1'b0, ac}, 8'h66);
        chk("view", {2'h0, view}, 8'h01);
        wr_i(8'h1c);
        chk("counter", {1'b0, ac}, 8'h67);
        chk("view", {2'h0, view}, 8'h00);
        wr_i(8'h10);
        chk("view", {2'h0, view}, 8'h00);
        wr_i(8'h45); wr_i(8'h14);
        chk("glyph sel", {7'h00, gsel}, 8'h00);
        chk("counter", {1'b0, ac}, 8'h06);
        wr_i(8'h06);
        $display("test shift done");
    endtask : t_shift

    task automatic t_clear();
        wr_i(8'h02); wr_i(8'h18);
        wr_i(8'h03);
        chk("counter", {1'b0, ac}, 8'h00);
        chk("view", {2'h0, view}, 8'h00);
        wr_i(8'h80); wr_d(8'h55); wr_i(8'h18); wr_i(8'h04); wr_i(8'h01);
        chk("step up", {7'h00, up}, 8'h01);
        chk("view", {2'h0, view}, 8'h00);
        chk("write valid", {7'h00, host.last_valid}, 8'h00);
        rd_d();
        chk("text 00", host.last_rd, 8'h20);
        wr_i(8'h7f); rd_d();
        chk("glyph kept", host.last_rd, 8'h1f);
        wr_i(8'hd3); host.access(1'b0, 1'b1, 8'h00);
        chk("addr read", host.last_rd, 8'h53);
        chk("read valid", {7'h00, host.last_valid}, 8'h01);
        chk("counter", {1'b0, ac}, 8'h53);
        $display("test clear done");
    endtask : t_clear

    task automatic t_decode();
        wr_i(8'h3f);
        chk("counter", {1'b0, ac}, 8'h53);
        chk("glyph sel", {7'h00, gsel}, 8'h00);
        wr_i(8'h0f);
        chk("display", {5'h00, don, con, bon}, 8'h07);
        chk("counter", {1'b0, ac}, 8'h53);
        wr_i(8'h08);
        chk("display", {5'h00, don, con, bon}, 8'h00);
        $display("test decode done");
    endtask : t_decode

    task automatic t_scan();
        int  n;
        logic p;
        wr_i(8'h02); wr_i(8'h4a); wr_d(8'hf5);
        wr_i(8'h85); wr_d(8'h09); wr_i(8'h0c);
        scan(1'b0, 5'h05, 3'h2);
        chk("bits", {3'h0, sbits}, 8'h15);
        chk("code", scode, 8'h09);
        chk("user", {7'h00, suser}, 8'h01);
        scan(1'b0, 5'h05, 3'h3);
        chk("bits", {3'h0, sbits}, 8'h00);
        wr_i(8'h0e); wr_i(8'h85);
        scan(1'b0, 5'h05, 3'h7);
        chk("cursor", {3'h0, sbits}, 8'h1f);
        scan(1'b0, 5'h05, 3'h2);
        chk("cursor", {3'h0, sbits}, 8'h15);
        wr_i(8'h08);
        scan(1'b0, 5'h05, 3'h2);
        chk("blank", {3'h0, sbits}, 8'h00);
        wr_i(8'h0d);
        p = ph;
        n = 0;
        while (ph === p && n < 40) begin
            @(negedge i_clk);
            n++;
        end
        p = ph;
        n = 0;
        while (ph === p && n < 40) begin
            @(negedge i_clk);
            n++;
        end
        chk("blink half", n[7:0], 8'h08);
        n = 0;
        while (ph !== 1'b1 && n < 40) begin
            @(negedge i_clk);
            n++;
        end
        scan(1'b0, 5'h05, 3'h2);
        chk("blink", {3'h0, sbits}, 8'h1f);
        $display("test scan done");
    endtask : t_scan

    // ==========================================================
    // Run
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_reset();
        t_text();
        t_glyph();
        t_shift();
        t_clear();
        t_decode();
        t_scan();
        complete_run();
    end
endmodule : test_char_display_instruction_unit

`default_nettype wire
